// ---- src/wdt_pkg.sv ----
// Package for the board watchdog: port address, control byte layout, timing constants.
// Assumes a 50 MHz system clock and an 8-bit I/O write port from the host side.
package wdt_pkg;

    // I/O port that takes the control byte
    localparam logic [15:0] CTRL_PORT_ADDR = 16'h0443;

    // Control byte field positions
    localparam int ENABLE_BIT = 7;
    localparam int MODE_BIT   = 6;
    localparam int PERIOD_MSB = 5;
    localparam int PERIOD_LSB = 0;

    // Control value after reset: disabled, IRQ mode, zero period
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Timebase
    localparam int CLK_HZ         = 50_000_000;
    localparam int TICK_PERIOD_MS = 1000;
    localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int TICK_CNT_W     = 26;

    // Length of the reset pulse to the system
    localparam int RESET_PULSE_US     = 1;
    localparam int RESET_PULSE_CYCLES = CLK_HZ / 1_000_000 * RESET_PULSE_US;
    localparam int PULSE_CNT_W        = 8;

    // Decoded control byte
    typedef struct packed {
        logic       enable;
        logic       reset_mode;
        logic [5:0] period_s;
    } ctrl_t;

    // Expiry actions
    typedef struct packed {
        logic sys_reset;
        logic irq9;
    } action_t;

endpackage : wdt_pkg

// ---- src/wdt_tick.sv ----
// One-second tick generator for the watchdog.
// Assumes clk at the package rate; clear restarts the second from its beginning.
`timescale 1ns/1ps
module wdt_tick #(
    parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic clear,
    // Tick out
    output logic      tick
);

    logic [wdt_pkg::TICK_CNT_W-1:0] cnt_q;
    wire                            at_end = (cnt_q == wdt_pkg::TICK_CNT_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst || clear || at_end)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst || clear)
            tick <= 1'b0;
        else
            tick <= at_end;
    end

endmodule : wdt_tick

// ---- src/board_watchdog_timer.sv ----
// Board watchdog: control byte write port, seconds countdown, reset or IRQ 9 on expiry.
// Assumes host I/O writes arrive as a one-cycle strobe with address and data, synchronous to clk.
`timescale 1ns/1ps
// Operation
// - Bit 7 enables, bit 6 picks reset versus IRQ 9, low bits give period.
// - Writing CFH to port 443 arms reset mode, resetting after 15 seconds.
// - A write with a new period cancels and restarts the countdown.
// - Writing C3H during reset countdown resets the system 3 seconds later.
// - Watchdog leaves every system reset disabled until an enabling write.
// - Each trigger write clears elapsed time and restarts the period.
// - Expiry gives a reset pulse or an IRQ 9 request per mode bit.
module board_watchdog_timer #(
    parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Host I/O write port
    input  wire logic        io_wr,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    // Time-out actions
    output logic             sys_reset_out,
    output logic             irq9_out,
    // Status indication
    output logic             wd_active
);

    // Countdown phases
    typedef enum logic [1:0] {
        WD_IDLE,
        WD_COUNT,
        WD_DONE
    } wd_state_t;

    // Splits a control byte into its fields
    function automatic wdt_pkg::ctrl_t decode_ctrl(input logic [7:0] b);
        wdt_pkg::ctrl_t c;
        c.enable     = b[wdt_pkg::ENABLE_BIT];
        c.reset_mode = b[wdt_pkg::MODE_BIT];
        c.period_s   = b[wdt_pkg::PERIOD_MSB:wdt_pkg::PERIOD_LSB];
        return c;
    endfunction : decode_ctrl

    // Zero period never arms; it would otherwise fire only when the seconds count wraps, on the 64th tick
    function automatic logic arms(input wdt_pkg::ctrl_t c);
        return c.enable && (c.period_s != 6'h00);
    endfunction : arms

    // Seconds step; wraps only past the largest period, which never counts that far
    function automatic logic [5:0] sec_inc(input logic [5:0] s);
        return s + 6'h01;
    endfunction : sec_inc

    wdt_pkg::ctrl_t                  ctrl_q;
    wdt_pkg::ctrl_t                  ctrl_d;
    wd_state_t                       state_q;
    wd_state_t                       state_d;
    logic [5:0]                      elapsed_q;
    logic [5:0]                      elapsed_d;
    logic [wdt_pkg::PULSE_CNT_W-1:0] pulse_q;
    logic [wdt_pkg::PULSE_CNT_W-1:0] pulse_d;
    logic                            sys_reset_d;
    logic                            irq9_d;
    logic                            active_d;
    logic                            tick;

    // Write decode
    wire                 ctrl_wr   = io_wr && (io_addr == wdt_pkg::CTRL_PORT_ADDR);
    wire wdt_pkg::ctrl_t wr_ctrl   = decode_ctrl(io_wdata);
    wire                 wr_arms   = arms(wr_ctrl);
    wire                 ctrl_arms = arms(ctrl_q);

    // Countdown progress
    wire                 running   = (state_q == WD_COUNT) && ctrl_arms;
    wire [5:0]           elapsed_n = sec_inc(elapsed_q);
    wire                 hit_end   = running && tick && (elapsed_n == ctrl_q.period_s);
    wire                 pulse_end = (pulse_q == wdt_pkg::PULSE_CNT_W'(wdt_pkg::RESET_PULSE_CYCLES - 1));

    // Expiry action picked by the mode bit
    wire wdt_pkg::action_t fire    = '{sys_reset: hit_end && ctrl_q.reset_mode,
                                       irq9:      hit_end && !ctrl_q.reset_mode};

    // Tick restarts with every control port write so a full second counts from the trigger
    wdt_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk   (clk),
        .rst   (rst),
        .clear (ctrl_wr),
        .tick  (tick)
    );

    // Control byte: any port write replaces it
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = wr_ctrl;
        end
    end

    // Phase: a write always wins over an expiry in the same cycle
    always_comb begin
        state_d = state_q;
        if (ctrl_wr) begin
            state_d = wr_arms ? WD_COUNT : WD_IDLE;
        end else begin
            unique case (state_q)
                WD_IDLE: begin
                    state_d = WD_IDLE;
                end
                WD_COUNT: begin
                    if (hit_end) begin
                        state_d = WD_DONE;
                    end
                end
                WD_DONE: begin
                    state_d = WD_DONE;
                end
                default: begin
                    state_d = WD_IDLE;
                end
            endcase
        end
    end

    // Elapsed seconds since the last trigger
    always_comb begin
        elapsed_d = elapsed_q;
        if (ctrl_wr) begin
            elapsed_d = 6'h00;
        end else if (running && tick) begin
            elapsed_d = elapsed_n;
        end
    end

    // Fixed-width system reset pulse
    always_comb begin
        sys_reset_d = sys_reset_out;
        if (fire.sys_reset) begin
            sys_reset_d = 1'b1;
        end else if (pulse_end) begin
            sys_reset_d = 1'b0;
        end
    end

    // Pulse width counter runs only while the pulse stands
    always_comb begin
        pulse_d = '0;
        if (sys_reset_out) begin
            pulse_d = pulse_q + 1'b1;
        end
    end

    // IRQ 9 held as a level until software writes the port again
    always_comb begin
        irq9_d = irq9_out;
        if (ctrl_wr) begin
            irq9_d = 1'b0;
        end else if (fire.irq9) begin
            irq9_d = 1'b1;
        end
    end

    // Status lags the countdown by one cycle
    always_comb begin
        active_d = running;
        if (ctrl_wr) begin
            active_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            ctrl_q <= wdt_pkg::CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            state_q <= WD_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            elapsed_q <= 6'h00;
        else
            elapsed_q <= elapsed_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            sys_reset_out <= 1'b0;
        else
            sys_reset_out <= sys_reset_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            pulse_q <= '0;
        else
            pulse_q <= pulse_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            irq9_out <= 1'b0;
        else
            irq9_out <= irq9_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            wd_active <= 1'b0;
        else
            wd_active <= active_d;
    end

endmodule : board_watchdog_timer

// ---- tb/wdt_asserts.sv ----
// Port checker for the board watchdog.
// Assumes it is bound into board_watchdog_timer; one clock domain.
`timescale 1ns/1ps
module wdt_asserts #(parameter int TICK_CYCLES = 10) (
    // Clock, reset and the watched ports
    input wire logic        clk, rst, io_wr, sys_reset_out, irq9_out, wd_active,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata
);
    logic [7:0]  ctl_q;
    logic [15:0] cnt_q;
    wire         wr  = io_wr && io_addr == 16'h0443;
    wire [15:0]  lim = 16'(ctl_q[5:0] * TICK_CYCLES);
    // Allows either registering depth behind the expiry edge
    wire         win = cnt_q == lim || cnt_q == lim + 16'h0001;
    always_ff @(posedge clk) begin
        ctl_q <= rst ? 8'h00 : wr ? io_wdata : ctl_q;
        cnt_q <= (rst || wr) ? 16'h0000 : cnt_q + 16'(cnt_q != 16'hffff);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_arm; wr && io_wdata[7] && io_wdata[5:0] != 6'h00 ##1 !io_wr ##1 !io_wr; endsequence
    property p_irq; $rose(irq9_out) |-> ctl_q[7] && !ctl_q[6] && win; endproperty
    a_irq: assert property (p_irq) else $error("irq timing");
    property p_rst; $rose(sys_reset_out) |-> ctl_q[7:6] == 2'b11 && win; endproperty
    a_rst: assert property (p_rst) else $error("reset timing");
    property p_pulse; $rose(sys_reset_out) |=> sys_reset_out[*7]; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse short");
    property p_off; $fell(rst) |-> !irq9_out && !sys_reset_out && !wd_active; endproperty
    a_off: assert property (p_off) else $error("not off");
    property p_dis; !ctl_q[7] && cnt_q > 16'h0001 |-> !wd_active && !irq9_out; endproperty
    a_dis: assert property (p_dis) else $error("disabled");
    property p_clr; wr |=> !irq9_out; endproperty
    a_clr: assert property (p_clr) else $error("irq kept");
    property p_arm; s_arm |-> wd_active; endproperty
    a_arm: assert property (p_arm) else $error("not armed");
    property p_stop; wd_active && cnt_q > 16'h0001 |-> ctl_q[7] && ctl_q[5:0] != 6'h00; endproperty
    a_stop: assert property (p_stop) else $error("active");
endmodule : wdt_asserts
bind board_watchdog_timer wdt_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_wdt_asserts (.*);

// ---- tb/host_io_model.sv ----
// Host software model: single byte writes on the I/O port.
// Assumes calls only after reset has been released.
`timescale 1ns/1ps
module host_io_model (
    // Clock
    input  wire logic  clk,
    // Write port
    output logic       io_wr,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata
);
    initial {io_wr, io_addr, io_wdata} = 25'h0000000;
    task automatic wr(input logic [15:0] a, input logic [7:0] b);
        @(posedge clk) #1;
        {io_wr, io_addr, io_wdata} = {1'b1, a, b};
        @(posedge clk) #1;
        // Released lines show no stale value
        {io_wr, io_addr, io_wdata} = {1'b0, ~a, ~b};
    endtask : wr
endmodule : host_io_model

// ---- tb/tb.sv ----
// Self-checking bench for the board watchdog, second shortened to 10 cycles.
// Assumes the host model drives the control port.
`timescale 1ns/1ps
module tb;
    logic        clk = 0, rst = 1, io_wr, sys_reset_out, irq9_out, wd_active;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    int          errors = 0, n_checks = 0;
    always #10 clk = ~clk;
    host_io_model u_host_io_model (.clk(clk), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata));
    board_watchdog_timer #(.TICK_CYCLES(10)) u_board_watchdog_timer (.*);
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // Optional earlier write, then a byte whose expiry is timed
    task automatic expire(input logic [7:0] pre, b);
        int n;
        if (pre != 8'h00) begin
            u_host_io_model.wr(16'h0443, pre);
            repeat (15) @(posedge clk);
        end
        u_host_io_model.wr(16'h0443, b);
        @(posedge clk) #1;
        chk(wd_active, 1);
        for (n = 1; n < 800 && !(irq9_out | sys_reset_out); n++) @(posedge clk) #1;
        if (n == 800) begin
            errors++;
            complete_run();
        end
        chk(n >= 10 * b[5:0] && n <= 10 * b[5:0] + 1, 1);
        chk({sys_reset_out, irq9_out}, b[6] ? 2'b10 : 2'b01);
        repeat (60) @(posedge clk);
        chk(irq9_out, !b[6]);
        u_host_io_model.wr(16'h0443, 8'h40);
        @(posedge clk) #1;
        chk({irq9_out, wd_active}, 0);
    endtask : expire
    // Reset in mid countdown must leave the watchdog off
    task automatic mid_reset;
        u_host_io_model.wr(16'h0443, 8'h81);
        repeat (5) @(posedge clk);
        #1 rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        chk({sys_reset_out, irq9_out, wd_active}, 0);
        repeat (30) @(posedge clk);
        #1 chk({sys_reset_out, irq9_out, wd_active}, 0);
    endtask : mid_reset
    // A disabling byte at the wrong address must not stop a running countdown
    task automatic wrong_addr;
        u_host_io_model.wr(16'h0443, 8'h81);
        u_host_io_model.wr(16'h0442, 8'h40);
        repeat (30) @(posedge clk);
        #1 chk(irq9_out, 1);
        u_host_io_model.wr(16'h0443, 8'h40);
        @(posedge clk) #1;
        chk(irq9_out, 0);
    endtask : wrong_addr
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        chk({sys_reset_out, irq9_out, wd_active}, 0);
        expire(8'h00, 8'h82);
        expire(8'h00, 8'hcf);
        expire(8'h88, 8'h83);
        expire(8'hcf, 8'hc3);
        expire(8'h82, 8'h82);
        mid_reset();
        wrong_addr();
        complete_run();
    end
endmodule : tb
